// ==== ccr_restore_regs.vh ====
// Purpose: constants for the coprocessor context-restore sequencer
// Assumes: interface register offsets are byte offsets from the register set base
// Notes: format word holds a format code in the upper byte and a byte length in the lower byte
`ifndef CCR_RESTORE_REGS_VH
`define CCR_RESTORE_REGS_VH

// interface register offsets
`define CCR_OFF_CONTROL 5'h02
`define CCR_OFF_RESTORE 5'h06
`define CCR_OFF_OPERAND 5'h10

// control register value that sets the abort flag
`define CCR_ABORT_MASK 16'h0001

// format word fields
`define CCR_FMT_CODE_HI 15
`define CCR_FMT_CODE_LO 8
`define CCR_FMT_LEN_HI 7
`define CCR_FMT_LEN_LO 0

// special format codes
`define CCR_FMT_EMPTY 8'h00
`define CCR_FMT_INVALID 8'h01

// operand transfer step, one long word
`define CCR_WORD_BYTES 32'h00000004
`define CCR_LEN_ROUND 9'h003

// fifo geometry
`define CCR_FIFO_WIDTH 32
`define CCR_FIFO_DEPTH 8
`define CCR_FIFO_AW 3

`endif

// ==== ccr_restore.v ====
// Purpose: main-processor side of the coprocessor context-restore dialog
// Assumes: all inputs synchronous to mclk; memory and coprocessor answer with one-cycle acks
// Notes: operand words are fetched into a fifo and drained to the operand register
`timescale 1ns/100ps
`include "ccr_restore_regs.vh"

// simple synchronous fifo with valid/ready on both sides
module ccr_fifo #(
   parameter WIDTH = `CCR_FIFO_WIDTH,
   parameter DEPTH = `CCR_FIFO_DEPTH,
   parameter AW = `CCR_FIFO_AW
) (
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // fill side
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // drain side
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] count_reg;
   wire push;
   wire pop;

   // handshake terms
   assign in_ready = (count_reg != DEPTH[AW:0]);
   assign out_valid = (count_reg != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr_reg];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // storage write
   always @(posedge mclk)
   begin
      if (push)
      begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // pointers and occupancy
   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop)
         begin
            rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
         end
         if (push && !pop)
         begin
            count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
         end
         else if (pop && !push)
         begin
            count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule // ccr_fifo

// Behaviour
// - processor reads the restore register back after writing the format word
// - valid format: copy bytes from effective address to operand register
// - empty/reset format: no operand bytes, go straight to finishing
// - byte count comes from the length field of the read-back word
// - invalid code read back: write abort mask to control, then format error
// - after transfer or skip, continue with the next instruction
// - supervisor flag is tested before any other step
// - supervisor clear: privilege violation, no interface register access
// - restore register sits at offset 0x06
// - operand register is 32 bits at offset 0x10
// - control register holds two bits; abort flag aborts the coprocessor
module ccr_restore (
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // instruction request
   input wire restore_start,
   input wire [15:0] restore_format,
   input wire [31:0] restore_ea,
   input wire processor_status_word_s,
   // instruction outcome
   output reg restore_busy,
   output reg finish_step,
   output reg priv_violation,
   output reg format_error,
   // interface register accesses
   output reg interface_register_req,
   output reg interface_register_wr,
   output reg [4:0] interface_register_addr,
   output reg [31:0] interface_register_wdata,
   input wire interface_register_ack,
   input wire [15:0] interface_register_rdata,
   // memory reads of the saved frame
   output reg mem_req,
   output reg [31:0] mem_addr,
   input wire mem_ack,
   input wire [31:0] mem_rdata
);
   localparam [6:0] ST_IDLE = 7'h01;
   localparam [6:0] ST_PRIV = 7'h02;
   localparam [6:0] ST_WRFMT = 7'h04;
   localparam [6:0] ST_RDFMT = 7'h08;
   localparam [6:0] ST_ABORT = 7'h10;
   localparam [6:0] ST_XFER = 7'h20;
   localparam [6:0] ST_FINISH = 7'h40;

   reg [6:0] state_reg;
   reg [15:0] fmt_hold_reg;
   reg [31:0] ea_hold_reg;
   reg [6:0] fetch_left_reg;
   reg [6:0] drain_left_reg;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [31:0] fifo_out_data;
   wire fifo_push;
   wire drain_go;
   wire [8:0] len_round;
   wire [6:0] word_count;

   // long words needed for the byte count in the read-back word
   assign len_round = {1'b0, interface_register_rdata[`CCR_FMT_LEN_HI:`CCR_FMT_LEN_LO]} + `CCR_LEN_ROUND;
   assign word_count = len_round[8:2];

   // fifo traffic
   assign fifo_push = mem_req & mem_ack;
   assign drain_go = (state_reg == ST_XFER) && !interface_register_req && fifo_out_valid &&
      (drain_left_reg != 7'h00);

   ccr_fifo #(
      .WIDTH(`CCR_FIFO_WIDTH),
      .DEPTH(`CCR_FIFO_DEPTH),
      .AW(`CCR_FIFO_AW)
   ) u_fifo (
      .mclk(mclk),
      .rst_n(rst_n),
      .in_valid(fifo_push),
      .in_ready(fifo_in_ready),
      .in_data(mem_rdata),
      .out_valid(fifo_out_valid),
      .out_ready(drain_go),
      .out_data(fifo_out_data)
   );

   // restore dialog sequencer
   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         state_reg <= ST_IDLE;
         fmt_hold_reg <= 16'h0000;
         ea_hold_reg <= 32'h00000000;
         fetch_left_reg <= 7'h00;
         drain_left_reg <= 7'h00;
         restore_busy <= 1'b0;
         finish_step <= 1'b0;
         priv_violation <= 1'b0;
         format_error <= 1'b0;
         interface_register_req <= 1'b0;
         interface_register_wr <= 1'b0;
         interface_register_addr <= 5'h00;
         interface_register_wdata <= 32'h00000000;
         mem_req <= 1'b0;
         mem_addr <= 32'h00000000;
      end
      else
      begin
         finish_step <= 1'b0;
         priv_violation <= 1'b0;
         format_error <= 1'b0;
         case (state_reg)
            ST_IDLE:
            begin
               if (restore_start)
               begin
                  fmt_hold_reg <= restore_format;
                  ea_hold_reg <= restore_ea;
                  restore_busy <= 1'b1;
                  state_reg <= ST_PRIV;
               end
            end
            ST_PRIV:
            begin
               // privilege test comes before any register access
               if (!processor_status_word_s)
               begin
                  priv_violation <= 1'b1;
                  restore_busy <= 1'b0;
                  state_reg <= ST_IDLE;
               end
               else
               begin
                  interface_register_req <= 1'b1;
                  interface_register_wr <= 1'b1;
                  interface_register_addr <= `CCR_OFF_RESTORE;
                  interface_register_wdata <= {fmt_hold_reg, 16'h0000};
                  state_reg <= ST_WRFMT;
               end
            end
            ST_WRFMT:
            begin
               // read the restore register back once the write lands
               if (interface_register_ack)
               begin
                  interface_register_wr <= 1'b0;
                  interface_register_addr <= `CCR_OFF_RESTORE;
                  state_reg <= ST_RDFMT;
               end
            end
            ST_RDFMT:
            begin
               if (interface_register_ack)
               begin
                  if (interface_register_rdata[`CCR_FMT_CODE_HI:`CCR_FMT_CODE_LO] == `CCR_FMT_INVALID)
                  begin
                     interface_register_wr <= 1'b1;
                     interface_register_addr <= `CCR_OFF_CONTROL;
                     interface_register_wdata <= {`CCR_ABORT_MASK, 16'h0000};
                     state_reg <= ST_ABORT;
                  end
                  else if (interface_register_rdata[`CCR_FMT_CODE_HI:`CCR_FMT_CODE_LO] == `CCR_FMT_EMPTY ||
                     word_count == 7'h00)
                  begin
                     interface_register_req <= 1'b0;
                     state_reg <= ST_FINISH;
                  end
                  else
                  begin
                     interface_register_req <= 1'b0;
                     interface_register_wr <= 1'b1;
                     interface_register_addr <= `CCR_OFF_OPERAND;
                     fetch_left_reg <= word_count;
                     drain_left_reg <= word_count;
                     mem_addr <= ea_hold_reg;
                     state_reg <= ST_XFER;
                  end
               end
            end
            ST_ABORT:
            begin
               // format error raised only after the abort write completes
               if (interface_register_ack)
               begin
                  interface_register_req <= 1'b0;
                  format_error <= 1'b1;
                  restore_busy <= 1'b0;
                  state_reg <= ST_IDLE;
               end
            end
            ST_XFER:
            begin
               // fetch side, held off while the fifo is full
               if (fifo_push)
               begin
                  mem_req <= 1'b0;
                  fetch_left_reg <= fetch_left_reg - 7'h01;
                  mem_addr <= mem_addr + `CCR_WORD_BYTES;
               end
               else if (!mem_req && fetch_left_reg != 7'h00 && fifo_in_ready)
               begin
                  mem_req <= 1'b1;
               end
               // drain side, one operand register write per word
               if (drain_go)
               begin
                  interface_register_req <= 1'b1;
                  interface_register_wdata <= fifo_out_data;
               end
               else if (interface_register_req && interface_register_ack)
               begin
                  interface_register_req <= 1'b0;
                  drain_left_reg <= drain_left_reg - 7'h01;
                  if (drain_left_reg == 7'h01)
                  begin
                     state_reg <= ST_FINISH;
                  end
               end
            end
            ST_FINISH:
            begin
               finish_step <= 1'b1;
               restore_busy <= 1'b0;
               state_reg <= ST_IDLE;
            end
            default:
            begin
               interface_register_req <= 1'b0;
               mem_req <= 1'b0;
               restore_busy <= 1'b0;
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // ccr_restore

// ==== ccr_restore_monitor.sv ====
// Purpose: port assertions for the context-restore sequencer
// Assumes: one clock, synchronous active-low reset
// Notes: bound into every ccr_restore instance
`timescale 1ns/100ps
module ccr_restore_monitor (
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // instruction side
   input wire processor_status_word_s,
   input wire restore_busy,
   input wire finish_step,
   input wire priv_violation,
   input wire format_error,
   // interface register port
   input wire interface_register_req,
   input wire interface_register_wr,
   input wire [4:0] interface_register_addr,
   input wire [31:0] interface_register_wdata,
   input wire interface_register_ack,
   input wire [15:0] interface_register_rdata
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // completed accesses of interest
   wire ireq = interface_register_req;
   wire iwr = interface_register_wr;
   wire [4:0] iaddr = interface_register_addr;
   wire [31:0] iwdata = interface_register_wdata;
   wire iack = interface_register_ack;
   wire [15:0] irdata = interface_register_rdata;
   wire wr_rst = ireq && iwr && iaddr == 5'h06 && iack;
   wire rd_rst = ireq && !iwr && iaddr == 5'h06 && iack;
   wire wr_op = ireq && iwr && iaddr == 5'h10 && iack;
   reg [8:0] left_reg;
   // operand long words still owed for this restore
   always @(posedge mclk)
   begin
      if (!rst_n)
         left_reg <= 9'h000;
      else if (rd_rst)
         left_reg <= (irdata[15:8] > 8'h01) ? ({1'b0, irdata[7:0]} + 9'h003) >> 2 : 9'h000;
      else if (wr_op)
         left_reg <= left_reg - 9'h001;
   end
   property p_super;
      $rose(restore_busy) && processor_status_word_s |=> ireq && iwr && iaddr == 5'h06 && !priv_violation;
   endproperty
   a_super: assert property (p_super) else $error("restore write missing");
   property p_user;
      $rose(restore_busy) && !processor_status_word_s |=> priv_violation && !ireq;
   endproperty
   a_user: assert property (p_user) else $error("privilege check wrong");
   property p_readback;
      wr_rst |=> ireq && !iwr && iaddr == 5'h06;
   endproperty
   a_readback: assert property (p_readback) else $error("read-back missing");
   property p_abort;
      rd_rst && irdata[15:8] == 8'h01 |=> ireq && iwr && iaddr == 5'h02 && iwdata[31:16] == 16'h0001;
   endproperty
   a_abort: assert property (p_abort) else $error("abort write missing");
   property p_ferr;
      ireq && iwr && iaddr == 5'h02 && iack |=> format_error && !ireq;
   endproperty
   a_ferr: assert property (p_ferr) else $error("format error missing");
   property p_empty;
      rd_rst && irdata[15:8] == 8'h00 |=> !ireq ##1 finish_step;
   endproperty
   a_empty: assert property (p_empty) else $error("empty frame not skipped");
   property p_count;
      finish_step |-> left_reg == 9'h000 && !restore_busy;
   endproperty
   a_count: assert property (p_count) else $error("finished with words owed");
   property p_extra;
      wr_op |-> left_reg != 9'h000;
   endproperty
   a_extra: assert property (p_extra) else $error("surplus operand write");
   c_priv: cover property (priv_violation);
   c_ferr: cover property (format_error);
   c_data: cover property (wr_op ##[1:300] finish_step);
endmodule // ccr_restore_monitor
bind ccr_restore ccr_restore_monitor i_ccr_restore_monitor (.*);

// ==== ccr_cop_model.sv ====
// Purpose: behavioural coprocessor and frame memory facing the sequencer
// Assumes: requests are held until acked
// Notes: format codes 80-ff are refused; slow stretches every answer
`timescale 1ns/100ps
module ccr_cop_model (
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // answer pacing
   input wire slow,
   // interface register port
   input wire interface_register_req,
   input wire interface_register_wr,
   input wire [4:0] interface_register_addr,
   input wire [31:0] interface_register_wdata,
   output reg interface_register_ack,
   output wire [15:0] interface_register_rdata,
   // frame memory port
   input wire mem_req,
   input wire [31:0] mem_addr,
   output reg mem_ack,
   output wire [31:0] mem_rdata
);
   reg [15:0] rst_reg;
   reg [2:0] tick_reg;
   reg [31:0] op_cnt;
   reg [31:0] op_sum;
   reg ctl_abort;
   // data only valid with ack, junk otherwise
   assign interface_register_rdata = interface_register_ack ? rst_reg : ~rst_reg;
   assign mem_rdata = mem_ack ? mem_addr ^ 32'h5a5a0000 : ~mem_addr;
   // answer each held request once
   always @(posedge mclk)
   begin
      interface_register_ack <= 1'b0;
      mem_ack <= 1'b0;
      if (!rst_n)
      begin
         tick_reg <= 3'h0;
         op_cnt <= 32'h0;
         op_sum <= 32'h0;
         ctl_abort <= 1'b0;
      end
      else
      begin
         tick_reg <= tick_reg + 3'h1;
         if (mem_req && !mem_ack && (!slow || tick_reg[0]))
            mem_ack <= 1'b1;
         if (interface_register_req && !interface_register_ack && (!slow || tick_reg == 3'h7))
         begin
            interface_register_ack <= 1'b1;
            if (interface_register_wr && interface_register_addr == 5'h06)
            begin
               rst_reg <= interface_register_wdata[31] ? 16'h0100 : interface_register_wdata[31:16];
               ctl_abort <= 1'b0;
            end
            if (interface_register_wr && interface_register_addr == 5'h10)
            begin
               op_cnt <= op_cnt + 32'h1;
               op_sum <= op_sum ^ interface_register_wdata;
            end
            if (interface_register_wr && interface_register_addr == 5'h02)
               ctl_abort <= interface_register_wdata[16];
         end
      end
   end
endmodule // ccr_cop_model

// ==== coprocessor_context_restore_bench.sv ====
// Purpose: self-checking bench for the context-restore sequencer
// Assumes: inputs change on the falling edge of mclk
// Notes: corner formats first, then lfsr-drawn ones
`timescale 1ns/100ps
module coprocessor_context_restore_bench;
   reg mclk, rst_n, restore_start, processor_status_word_s, slow, touched;
   reg [15:0] restore_format;
   reg [31:0] restore_ea, seed, cyc;
   wire restore_busy, finish_step, priv_violation, format_error, ir_req, ir_wr, ir_ack, mem_req, mem_ack;
   wire [4:0] ir_addr;
   wire [15:0] ir_rdata;
   wire [31:0] ir_wdata, mem_addr, mem_rdata;
   integer num_errors, compares, k;
   ccr_restore i_ccr_restore (.mclk(mclk), .rst_n(rst_n), .restore_start(restore_start),
      .restore_format(restore_format), .restore_ea(restore_ea), .processor_status_word_s(processor_status_word_s),
      .restore_busy(restore_busy), .finish_step(finish_step), .priv_violation(priv_violation),
      .format_error(format_error), .interface_register_req(ir_req), .interface_register_wr(ir_wr),
      .interface_register_addr(ir_addr), .interface_register_wdata(ir_wdata), .interface_register_ack(ir_ack),
      .interface_register_rdata(ir_rdata), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata));
   ccr_cop_model i_ccr_cop_model (.mclk(mclk), .rst_n(rst_n), .slow(slow), .interface_register_req(ir_req),
      .interface_register_wr(ir_wr), .interface_register_addr(ir_addr), .interface_register_wdata(ir_wdata),
      .interface_register_ack(ir_ack), .interface_register_rdata(ir_rdata), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   // clock and hang guard
   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cyc <= cyc + 32'h1;
      if (ir_req)
         touched <= 1'b1;
      if (cyc == 32'd60000)
      begin
         num_errors = num_errors + 1;
         test_done;
      end
   end
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // long words owed; only codes 02..7f carry data
   function [31:0] words(input [15:0] f);
      words = (f[15:8] > 8'h01 && !f[15]) ? ({24'h0, f[7:0]} + 32'h3) >> 2 : 32'h0;
   endfunction
   task chk(input [8*10-1:0] what, input [31:0] exp, input [31:0] got);
      begin
         compares = compares + 1;
         if (exp !== got)
         begin
            $display("[FAIL] %0s expected %h seen %h", what, exp, got);
            num_errors = num_errors + 1;
         end
      end
   endtask
   // one restore instruction, called at a falling edge
   task run(input [15:0] f, input s);
      integer n;
      reg [31:0] c0, s0, sum;
      reg bad;
      begin
         bad = f[15] || f[15:8] == 8'h01;
         c0 = i_ccr_cop_model.op_cnt;
         s0 = i_ccr_cop_model.op_sum;
         sum = 32'h0;
         for (n = 0; n < words(f); n = n + 1)
            sum = sum ^ (restore_ea + 4 * n) ^ 32'h5a5a0000;
         touched = 1'b0;
         restore_format = f;
         processor_status_word_s = s;
         restore_start = 1'b1;
         @(negedge mclk);
         restore_start = 1'b0;
         n = 0;
         while (!(finish_step || priv_violation || format_error) && n < 3000)
         begin
            @(posedge mclk);
            #1;
            n = n + 1;
         end
         chk("privilege", {31'h0, !s}, {31'h0, priv_violation});
         chk("touched", {31'h0, s}, {31'h0, touched});
         chk("fmt error", {31'h0, s && bad}, {31'h0, format_error});
         chk("finish", {31'h0, s && !bad}, {31'h0, finish_step});
         chk("words", s ? words(f) : 32'h0, i_ccr_cop_model.op_cnt - c0);
         chk("data", s ? sum : 32'h0, i_ccr_cop_model.op_sum ^ s0);
         if (s)
            chk("abort", {31'h0, bad}, {31'h0, i_ccr_cop_model.ctl_abort});
         $display("test fmt %h super %0d done", f, s);
         @(negedge mclk);
         @(negedge mclk);
      end
   endtask
   task test_done;
      begin
         $display("compares %0d num_errors %0d", compares, num_errors);
         if (num_errors == 0 && compares > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   // main sequence
   initial
   begin
      num_errors = 0;
      compares = 0;
      cyc = 32'h0;
      seed = 32'h09f4;
      rst_n = 1'b0;
      restore_start = 1'b0;
      processor_status_word_s = 1'b0;
      slow = 1'b0;
      touched = 1'b0;
      restore_format = 16'h0000;
      restore_ea = 32'h00001000;
      repeat (10) @(negedge mclk);
      rst_n = 1'b1;
      @(negedge mclk);
      run(16'h0408, 1'b0);
      run(16'h8010, 1'b1);
      run(16'h0020, 1'b1);
      run(16'h0201, 1'b1);
      slow = 1'b1;
      run(16'h7fff, 1'b1);
      for (k = 0; k < 40; k = k + 1)
      begin
         seed = lfsr(seed);
         slow = seed[20];
         restore_ea = {16'h0, seed[31:18], 2'h0};
         run(seed[15:0], seed[16] | seed[17]);
      end
      test_done;
   end
endmodule // coprocessor_context_restore_bench
